/* include/clk_pm_pkg.sv */
// Constants for the CPU clock source and power control block.
// Assumes a Wishbone slave with 32-bit data and byte addresses.
package clk_pm_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
  localparam logic [7:0] IDX_EXT_FLAGS     = 8'h91;
  localparam logic [7:0] IDX_POWER_MGMT    = 8'hC4;
  localparam logic [7:0] IDX_STATUS        = 8'hC5;
  // Field positions
  localparam int POS_IDLE       = 0;
  localparam int POS_SRC_SEL    = 3;
  localparam int POS_RING_FLAG  = 2;
  localparam int POS_RATE_LO    = 6;
  localparam int POS_SWB        = 5;
  localparam int POS_AMP_DIS    = 3;
  localparam int POS_XT_READY   = 4;
  // Cycle-rate codes and reset values
  localparam logic [1:0] RATE_4    = 2'h1;
  localparam logic [1:0] RATE_64   = 2'h2;
  localparam logic [1:0] RATE_1024 = 2'h3;
  localparam logic [1:0] RATE_RSVD = 2'h0;
  localparam logic       RST_SRC_SEL = 1'h1;
  localparam logic       RST_SWB     = 1'h0;
  localparam logic       RST_AMP_DIS = 1'h0;
  localparam logic [7:0] RST_STATUS  = 8'h10;
  // Last count of each machine-cycle divide
  localparam logic [9:0] LAST_4    = 10'h003;
  localparam logic [9:0] LAST_64   = 10'h03F;
  localparam logic [9:0] LAST_1024 = 10'h3FF;
  // Crystal warm-up length in crystal clocks
  localparam int XTAL_WARM_CLOCKS = 65536;
  // Crystal oscillator states
  typedef enum logic [2:0] {
    XT_RUN  = 3'h1,
    XT_OFF  = 3'h2,
    XT_WARM = 3'h4
  } xtal_state_e;
endpackage : clk_pm_pkg

/* rtl/warmup_counter.sv */
// Crystal warm-up counter: counts crystal ticks, flags completion.
// Assumes i_tick is a one-cycle pulse already in the i_clk domain.
`timescale 1ns/1ns
module warmup_counter #(
  parameter int COUNT = 65536
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rstn,
  // Control
  input  wire logic i_clear,
  input  wire logic i_tick,
  // Status
  output logic      o_done
);
  localparam int W = $clog2(COUNT + 1);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         done_reg;
  logic         done_next;

  always_comb begin
    cnt_next  = cnt_reg;
    done_next = done_reg;
    if (i_clear) begin
      cnt_next  = '0;
      done_next = 1'b0;
    end else if (i_tick && !done_reg) begin
      cnt_next = cnt_reg + W'(1);
      if (cnt_reg == W'(COUNT - 1)) begin
        done_next = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_reg  <= '0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign o_done = done_reg;
endmodule : warmup_counter

/* rtl/cpu_clock_source_power_control.sv */
// CPU clock source selection, cycle-rate divider, crystal warm-up
// and idle control, reached over a classic Wishbone slave.
// Assumes oscillator pins are asynchronous; CPU status inputs are on i_clk.
//
// Overview of operation
// - Source select bit one picks crystal, zero picks the ring oscillator.
// - After reset the CPU runs from the crystal.
// - Read-only ring flag shows one while running from the ring; resets zero.
// - Amplifier disable may be set only with source select zero; resets zero.
// - Source change applies one machine cycle after the write.
// - Clearing amplifier disable restarts crystal; 65,536 clocks later ready sets.
// - Select zero-to-one ignored unless ready is one and amplifier enabled.
// - Switchback restores only divide-by-4; clock source stays unchanged.
// - Rate 01 is 4 clocks, 10 and 11 reduced; reduced only from 01.
// - Switchback enable is free to write, resets zero, gates hardware switchback.
// - Three read-only in-service bits for power-fail, high, low priority.
// - Four read-only serial activity bits in positions three to zero.
// - Crystal ready bit is read-only and resets to one.
// - Power control bit zero halts the CPU while clocks keep running.
// - Idle ends on any interrupt or on reset.
// - Rate change applies one machine cycle later, for all functions.
// - Switchback on serviceable external interrupt, start bit, or transmit write.
`timescale 1ns/1ns
module cpu_clock_source_power_control #(
  parameter int WARM_COUNT = clk_pm_pkg::XTAL_WARM_CLOCKS
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // Wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [11:0] i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // Oscillator pins
  input  wire logic        i_xtal_osc,
  input  wire logic        i_ring_osc,
  // CPU status
  input  wire logic        i_powerfail_irq_in_service,
  input  wire logic        i_high_irq_in_service,
  input  wire logic        i_low_irq_in_service,
  input  wire logic        i_serial1_tx_active,
  input  wire logic        i_serial1_rx_active,
  input  wire logic        i_serial0_tx_active,
  input  wire logic        i_serial0_rx_active,
  // Wake events
  input  wire logic        i_irq_event,
  input  wire logic        i_ext_irq_wake,
  input  wire logic        i_serial_start_bit,
  input  wire logic        i_serial_tx_write,
  // Clock control outputs
  output logic             o_machine_cycle,
  output logic [1:0]       o_cycle_rate,
  output logic             o_ring_active,
  output logic             o_xtal_amp_enable,
  output logic             o_xtal_ready,
  output logic             o_cpu_halt
);
  function automatic logic [9:0] div_last(input logic [1:0] code);
    case (code)
      clk_pm_pkg::RATE_64:   div_last = clk_pm_pkg::LAST_64;
      clk_pm_pkg::RATE_1024: div_last = clk_pm_pkg::LAST_1024;
      default:               div_last = clk_pm_pkg::LAST_4;
    endcase
  endfunction : div_last

  // Oscillator synchronisers and edge detect
  logic [2:0] xt_sync_reg;
  logic [2:0] rg_sync_reg;
  logic       xt_tick;
  logic       rg_tick;
  logic       src_tick;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      xt_sync_reg <= 3'h0;
      rg_sync_reg <= 3'h0;
    end else begin
      xt_sync_reg <= {xt_sync_reg[1:0], i_xtal_osc};
      rg_sync_reg <= {rg_sync_reg[1:0], i_ring_osc};
    end
  end

  assign xt_tick  = xt_sync_reg[1] && !xt_sync_reg[2];
  assign rg_tick  = rg_sync_reg[1] && !rg_sync_reg[2];

  // State
  logic        ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic        sel_reg, sel_next;
  logic        ring_reg, ring_next;
  logic        amp_dis_reg, amp_dis_next;
  logic [1:0]  rate_reg, rate_next;
  logic [1:0]  rate_app_reg, rate_app_next;
  logic        swb_reg, swb_next;
  logic        idle_reg, idle_next;
  logic [7:0]  stat_reg, stat_next;
  logic [9:0]  div_reg, div_next;
  logic        mc_reg, mc_next;
  logic        warm_done;
  logic        req;
  logic        wr;
  logic [7:0]  idx;
  logic [7:0]  wd;
  logic        wr_pmr;
  logic        wake;
  logic        xt_ready;
  clk_pm_pkg::xtal_state_e xs_reg, xs_next;

  assign src_tick = ring_reg ? rg_tick : xt_tick;
  assign req      = i_wb_cyc && i_wb_stb;
  assign idx      = i_wb_adr[9:2];
  assign wd       = i_wb_dat[7:0];
  assign wr       = req && i_wb_we && ack_reg && i_wb_sel[0];
  assign wr_pmr   = wr && (idx == clk_pm_pkg::IDX_POWER_MGMT);
  assign wake     = i_ext_irq_wake || i_serial_start_bit || i_serial_tx_write;
  assign xt_ready = (xs_reg == clk_pm_pkg::XT_RUN);

  warmup_counter #(
    .COUNT (WARM_COUNT)
  ) u_warm (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_clear (xs_reg != clk_pm_pkg::XT_WARM),
    .i_tick  (xt_tick),
    .o_done  (warm_done)
  );

  // Bus, register and clock control next values
  always_comb begin
    ack_next      = req && !ack_reg;
    rdat_next     = rdat_reg;
    sel_next      = sel_reg;
    ring_next     = ring_reg;
    amp_dis_next  = amp_dis_reg;
    rate_next     = rate_reg;
    rate_app_next = rate_app_reg;
    swb_next      = swb_reg;
    idle_next     = idle_reg;
    xs_next       = xs_reg;
    mc_next       = 1'b0;
    div_next      = div_reg;
    stat_next     = {i_powerfail_irq_in_service, i_high_irq_in_service,
                     i_low_irq_in_service, xt_ready,
                     i_serial1_tx_active, i_serial1_rx_active,
                     i_serial0_tx_active, i_serial0_rx_active};
    // Read data; unmapped indices read zero
    if (req && !i_wb_we && !ack_reg) begin
      rdat_next = 32'h0;
      if (idx == clk_pm_pkg::IDX_POWER_CONTROL) begin
        rdat_next[clk_pm_pkg::POS_IDLE] = idle_reg;
      end else if (idx == clk_pm_pkg::IDX_EXT_FLAGS) begin
        rdat_next[clk_pm_pkg::POS_SRC_SEL]   = sel_reg;
        rdat_next[clk_pm_pkg::POS_RING_FLAG] = ring_reg;
      end else if (idx == clk_pm_pkg::IDX_POWER_MGMT) begin
        rdat_next[clk_pm_pkg::POS_RATE_LO+:2] = rate_reg;
        rdat_next[clk_pm_pkg::POS_SWB]        = swb_reg;
        rdat_next[clk_pm_pkg::POS_AMP_DIS]    = amp_dis_reg;
      end else if (idx == clk_pm_pkg::IDX_STATUS) begin
        rdat_next[7:0] = stat_reg;
      end
    end
    // Register writes
    if (wr && idx == clk_pm_pkg::IDX_EXT_FLAGS) begin
      if (!wd[clk_pm_pkg::POS_SRC_SEL]) begin
        sel_next = 1'b0;
      end else if (xt_ready && !amp_dis_reg) begin
        sel_next = 1'b1;
      end
    end
    if (wr_pmr) begin
      swb_next = wd[clk_pm_pkg::POS_SWB];
      if (wd[clk_pm_pkg::POS_RATE_LO+:2] == clk_pm_pkg::RATE_4) begin
        rate_next = clk_pm_pkg::RATE_4;
      end else if (wd[clk_pm_pkg::POS_RATE_LO+:2] != clk_pm_pkg::RATE_RSVD
                   && rate_reg == clk_pm_pkg::RATE_4) begin
        rate_next = wd[clk_pm_pkg::POS_RATE_LO+:2];
      end
      if (!wd[clk_pm_pkg::POS_AMP_DIS]) begin
        amp_dis_next = 1'b0;
      end else if (!sel_reg && ring_reg) begin
        amp_dis_next = 1'b1;
      end
    end
    if (wr && idx == clk_pm_pkg::IDX_POWER_CONTROL) begin
      idle_next = wd[clk_pm_pkg::POS_IDLE];
    end
    // Hardware switchback wins over a write; divider only
    if (swb_reg && wake) begin
      rate_next = clk_pm_pkg::RATE_4;
    end
    if (i_irq_event) begin
      idle_next = 1'b0;
    end
    // Machine-cycle divider
    if (src_tick) begin
      if (div_reg >= div_last(rate_app_reg)) begin
        div_next = 10'h000;
        mc_next  = 1'b1;
      end else begin
        div_next = div_reg + 10'h001;
      end
    end
    // Source and rate changes land on the next machine cycle
    if (mc_reg) begin
      rate_app_next = rate_reg;
      ring_next     = !sel_reg;
    end
    // Crystal oscillator control
    case (xs_reg)
      clk_pm_pkg::XT_RUN:  if (amp_dis_reg) xs_next = clk_pm_pkg::XT_OFF;
      clk_pm_pkg::XT_OFF:  if (!amp_dis_reg) xs_next = clk_pm_pkg::XT_WARM;
      clk_pm_pkg::XT_WARM: begin
        if (amp_dis_reg) begin
          xs_next = clk_pm_pkg::XT_OFF;
        end else if (warm_done) begin
          xs_next = clk_pm_pkg::XT_RUN;
        end
      end
      default:             xs_next = clk_pm_pkg::XT_RUN;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ack_reg      <= 1'b0;
      rdat_reg     <= 32'h0;
      sel_reg      <= clk_pm_pkg::RST_SRC_SEL;
      ring_reg     <= 1'b0;
      amp_dis_reg  <= clk_pm_pkg::RST_AMP_DIS;
      rate_reg     <= clk_pm_pkg::RATE_4;
      rate_app_reg <= clk_pm_pkg::RATE_4;
      swb_reg      <= clk_pm_pkg::RST_SWB;
      idle_reg     <= 1'b0;
      stat_reg     <= clk_pm_pkg::RST_STATUS;
      div_reg      <= 10'h000;
      mc_reg       <= 1'b0;
      xs_reg       <= clk_pm_pkg::XT_RUN;
    end else begin
      ack_reg      <= ack_next;
      rdat_reg     <= rdat_next;
      sel_reg      <= sel_next;
      ring_reg     <= ring_next;
      amp_dis_reg  <= amp_dis_next;
      rate_reg     <= rate_next;
      rate_app_reg <= rate_app_next;
      swb_reg      <= swb_next;
      idle_reg     <= idle_next;
      stat_reg     <= stat_next;
      div_reg      <= div_next;
      mc_reg       <= mc_next;
      xs_reg       <= xs_next;
    end
  end

  assign o_wb_ack          = ack_reg;
  assign o_wb_dat          = rdat_reg;
  assign o_machine_cycle   = mc_reg;
  assign o_cycle_rate      = rate_app_reg;
  assign o_ring_active     = ring_reg;
  assign o_xtal_amp_enable = !amp_dis_reg;
  assign o_xtal_ready      = stat_reg[clk_pm_pkg::POS_XT_READY];
  assign o_cpu_halt        = idle_reg;

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_amp_restart;
    $fell(amp_dis_reg);
  endsequence
  sequence s_not_ready2;
    !xt_ready [*2];
  endsequence

  property p_sel_guard;
    $rose(sel_reg) |-> $past(xt_ready) && !$past(amp_dis_reg);
  endproperty
  a_sel_guard: assert property (p_sel_guard) else $error("select rose without ready");

  property p_amp_guard;
    $rose(amp_dis_reg) |-> !$past(sel_reg) && $past(ring_reg);
  endproperty
  a_amp_guard: assert property (p_amp_guard) else $error("amp off while crystal");

  property p_src_apply;
    (mc_reg && (ring_reg == sel_reg)) |=> (ring_reg == !$past(sel_reg));
  endproperty
  a_src_apply: assert property (p_src_apply) else $error("source not applied");

  property p_rate_guard;
    ($changed(rate_reg) && rate_reg[1]) |-> $past(rate_reg) == clk_pm_pkg::RATE_4;
  endproperty
  a_rate_guard: assert property (p_rate_guard) else $error("reduced rate not from 4");

  property p_swb_off;
    (!$past(swb_reg) && $changed(rate_reg)) |-> $past(wr_pmr);
  endproperty
  a_swb_off: assert property (p_swb_off) else $error("rate changed without write");

  property p_switchback;
    (swb_reg && wake) |=> rate_reg == clk_pm_pkg::RATE_4 && sel_reg == $past(sel_reg);
  endproperty
  a_switchback: assert property (p_switchback) else $error("switchback failed");

  property p_warm;
    s_amp_restart |-> s_not_ready2;
  endproperty
  a_warm: assert property (p_warm) else $error("ready too early");

  property p_rate_apply;
    $changed(rate_app_reg) |-> $past(mc_reg);
  endproperty
  a_rate_apply: assert property (p_rate_apply) else $error("rate applied off cycle");

  property p_idle_exit;
    i_irq_event |=> !o_cpu_halt;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle not left");
endmodule : cpu_clock_source_power_control

/* dv/tb_cpu_clock_source_power_control.sv */
// Self-checking bench for the clock source and power control block.
// Assumes clk_pm_pkg is compiled first; bench drives every block input.
`timescale 1ns/1ns
module tb_cpu_clock_source_power_control;
  logic        i_clk;
  logic        i_rstn;
  logic        cyc;
  logic        stb;
  logic        we;
  logic        xo;
  logic        ro;
  logic [11:0] adr;
  logic [31:0] dat;
  logic [31:0] o_wb_dat;
  logic [7:0]  stv;
  logic [7:0]  q;
  logic [3:0]  wk;
  logic [1:0]  oc;
  logic [1:0]  o_cycle_rate;
  logic        o_wb_ack;
  logic        o_machine_cycle;
  logic        o_ring_active;
  logic        o_xtal_amp_enable;
  logic        o_xtal_ready;
  logic        o_cpu_halt;
  int          error_cnt;
  int          n_compared;
  int          k;
  localparam logic [11:0] A_PC = {2'h0, clk_pm_pkg::IDX_POWER_CONTROL, 2'h0};
  localparam logic [11:0] A_EX = {2'h0, clk_pm_pkg::IDX_EXT_FLAGS, 2'h0};
  localparam logic [11:0] A_PM = {2'h0, clk_pm_pkg::IDX_POWER_MGMT, 2'h0};
  localparam logic [11:0] A_ST = {2'h0, clk_pm_pkg::IDX_STATUS, 2'h0};
  localparam logic [1:0]  R4 = clk_pm_pkg::RATE_4;
  localparam logic [1:0]  R64 = clk_pm_pkg::RATE_64;
  localparam logic [1:0]  R1K = clk_pm_pkg::RATE_1024;

  cpu_clock_source_power_control #(.WARM_COUNT(8)) dut_u (
    .i_clk                      (i_clk),
    .i_rstn                     (i_rstn),
    .i_wb_cyc                   (cyc),
    .i_wb_stb                   (stb),
    .i_wb_we                    (we),
    .i_wb_adr                   (adr),
    .i_wb_sel                   (4'hF),
    .i_wb_dat                   (dat),
    .o_wb_dat                   (o_wb_dat),
    .o_wb_ack                   (o_wb_ack),
    .i_xtal_osc                 (xo),
    .i_ring_osc                 (ro),
    .i_powerfail_irq_in_service (stv[7]),
    .i_high_irq_in_service      (stv[6]),
    .i_low_irq_in_service       (stv[5]),
    .i_serial1_tx_active        (stv[3]),
    .i_serial1_rx_active        (stv[2]),
    .i_serial0_tx_active        (stv[1]),
    .i_serial0_rx_active        (stv[0]),
    .i_irq_event                (wk[0]),
    .i_ext_irq_wake             (wk[1]),
    .i_serial_start_bit         (wk[2]),
    .i_serial_tx_write          (wk[3]),
    .o_machine_cycle            (o_machine_cycle),
    .o_cycle_rate               (o_cycle_rate),
    .o_ring_active              (o_ring_active),
    .o_xtal_amp_enable          (o_xtal_amp_enable),
    .o_xtal_ready               (o_xtal_ready),
    .o_cpu_halt                 (o_cpu_halt)
  );

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // Oscillators at a quarter of i_clk; crystal pin dead while amp is off
  always @(posedge i_clk) begin
    oc <= oc + 2'h1;
    xo <= o_xtal_amp_enable ? oc[1] : 1'b0;
    ro <= oc[1];
  end

  task chk(input logic [15:0] e, input logic [15:0] g, input string nm);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task wb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {24'h0, d};
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_wb_ack !== 1'b1 && k < 20);
    chk(1'b1, o_wb_ack, "wb_ack");
    q = o_wb_dat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge i_clk);
  endtask : wb

  task rd(input logic [11:0] a, input logic [7:0] e, input string nm);
    wb(1'b0, a, 8'h00);
    chk(e, q, nm);
  endtask : rd

  function automatic logic [7:0] pm(input logic [1:0] r, input logic s, input logic x);
    return {r, s, 1'b0, x, 3'h0};
  endfunction : pm

  task pulse(input int i);
    @(posedge i_clk);
    wk[i] <= 1'b1;
    @(posedge i_clk);
    wk <= 4'h0;
  endtask : pulse

  task wait_rate(input logic [1:0] r);
    for (k = 0; k < 5000 && o_cycle_rate !== r; k++) @(negedge i_clk);
    chk(r, o_cycle_rate, "cycle_rate");
  endtask : wait_rate

  // Clocks between two machine-cycle pulses
  task per(input logic [15:0] e, input string nm);
    int c;
    @(negedge i_clk);
    for (k = 0; k < 5000 && o_machine_cycle !== 1'b1; k++) @(negedge i_clk);
    c = 0;
    do begin
      @(negedge i_clk);
      c++;
    end while (o_machine_cycle !== 1'b1 && c < 5000);
    chk(e, c[15:0], nm);
  endtask : per

  task t_reset;
    @(negedge i_clk);
    chk(1'b1, o_xtal_ready, "xtal_ready");
    chk(R4, o_cycle_rate, "cycle_rate");
    chk(1'b1, o_xtal_amp_enable, "amp_enable");
    chk(1'b0, o_ring_active, "ring_active");
    rd(A_EX, 8'h08, "ext_flags");
    rd(A_PM, pm(R4, 1'b0, 1'b0), "power_mgmt");
    rd(A_ST, 8'h10, "status");
    rd(A_PC, 8'h00, "power_control");
    wb(1'b1, A_ST, 8'h00);
    rd(A_ST, 8'h10, "status_ro");
    rd(12'h000, 8'h00, "unmapped");
    per(16'd16, "period_4");
  endtask : t_reset

  task t_status;
    @(posedge i_clk);
    stv <= 8'hA5;
    repeat (3) @(posedge i_clk);
    rd(A_ST, 8'hB5, "status_a5");
    stv <= 8'h4A;
    repeat (3) @(posedge i_clk);
    rd(A_ST, 8'h5A, "status_4a");
    stv <= 8'h00;
  endtask : t_status

  task t_rate;
    wb(1'b1, A_PM, pm(R64, 1'b0, 1'b0));
    wait_rate(R64);
    per(16'd256, "period_64");
    wb(1'b1, A_PM, pm(R1K, 1'b0, 1'b0));
    rd(A_PM, pm(R64, 1'b0, 1'b0), "rate_64_to_1024");
    wb(1'b1, A_PM, pm(R4, 1'b0, 1'b0));
    wait_rate(R4);
    wb(1'b1, A_PM, pm(R1K, 1'b0, 1'b0));
    wait_rate(R1K);
    per(16'd4096, "period_1024");
    wb(1'b1, A_PM, pm(2'h0, 1'b0, 1'b0));
    rd(A_PM, pm(R1K, 1'b0, 1'b0), "rate_reserved");
    wb(1'b1, A_PM, pm(R4, 1'b0, 1'b0));
    wait_rate(R4);
  endtask : t_rate

  task t_src;
    wb(1'b1, A_PM, pm(R4, 1'b0, 1'b1));
    rd(A_PM, pm(R4, 1'b0, 1'b0), "amp_off_on_xtal");
    wb(1'b1, A_EX, 8'h00);
    for (k = 0; k < 40 && o_ring_active !== 1'b1; k++) @(negedge i_clk);
    chk(1'b1, o_ring_active, "to_ring");
    rd(A_EX, 8'h04, "ext_ring");
    wb(1'b1, A_PM, pm(R4, 1'b0, 1'b1));
    chk(1'b0, o_xtal_amp_enable, "amp_off");
    rd(A_ST, 8'h00, "status_off");
    wb(1'b1, A_EX, 8'h08);
    rd(A_EX, 8'h04, "sel_amp_off");
    for (int i = 1; i < 4; i++) begin
      wb(1'b1, A_PM, pm(R64, 1'b1, 1'b1));
      wait_rate(R64);
      pulse(i);
      rd(A_PM, pm(R4, 1'b1, 1'b1), "switchback");
      chk(1'b1, o_ring_active, "ring_kept");
      wait_rate(R4);
    end
    wb(1'b1, A_PM, pm(R64, 1'b0, 1'b1));
    wait_rate(R64);
    pulse(1);
    rd(A_PM, pm(R64, 1'b0, 1'b1), "no_switchback");
    wb(1'b1, A_PM, pm(R4, 1'b0, 1'b1));
    wait_rate(R4);
    wb(1'b1, A_PM, pm(R4, 1'b0, 1'b0));
    wb(1'b1, A_EX, 8'h08);
    rd(A_EX, 8'h04, "sel_not_ready");
    chk(1'b0, o_xtal_ready, "early_ready");
    for (k = 0; k < 200 && o_xtal_ready !== 1'b1; k++) @(negedge i_clk);
    rd(A_ST, 8'h10, "status_ready");
    wb(1'b1, A_EX, 8'h08);
    for (k = 0; k < 40 && o_ring_active !== 1'b0; k++) @(negedge i_clk);
    chk(1'b0, o_ring_active, "to_xtal");
    rd(A_EX, 8'h08, "ext_xtal");
  endtask : t_src

  task t_idle;
    wb(1'b1, A_PC, 8'h01);
    chk(1'b1, o_cpu_halt, "halt");
    per(16'd16, "period_idle");
    pulse(0);
    repeat (2) @(negedge i_clk);
    chk(1'b0, o_cpu_halt, "irq_wake");
    wb(1'b1, A_PC, 8'h01);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    @(negedge i_clk);
    chk(1'b0, o_cpu_halt, "reset_wake");
    rd(A_PC, 8'h00, "power_control_rst");
  endtask : t_idle

  task wrap_up;
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (60000) @(posedge i_clk);
    $display("ERROR watchdog expected finish seen timeout");
    error_cnt++;
    wrap_up();
  end

  initial begin
    i_rstn = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 12'h000;
    dat = 32'h0;
    stv = 8'h00;
    wk = 4'h0;
    oc = 2'h0;
    xo = 1'b0;
    ro = 1'b0;
    error_cnt = 0;
    n_compared = 0;
    repeat (4) @(posedge i_clk);
    i_rstn <= 1'b1;
    t_reset();
    t_status();
    t_rate();
    t_src();
    t_idle();
    wrap_up();
  end
endmodule : tb_cpu_clock_source_power_control
